// ### dv/wdtrw_chk.sv
// checker for the watchdog block: chip reset, wake and bus answers at the top ports
// assumes ticks stay high and low for at least two clocks each, as the bench drives them
`timescale 1ns/100ps
`include "wdtrw_regs.vh"
module wdtrw_chk
#(
  parameter CNT_W = `WDTRW_CNT_W,
  parameter GRACE = `WDTRW_GRACE_TICKS,
  parameter HOLD  = `WDTRW_HOLD_TICKS
)
(
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [2:0]  hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic        hready_in,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic [31:0] hrdata_out,
  input wire logic        wd_tick_clock_in,
  input wire logic        pwr_down_in,
  input wire logic        chip_reset_out,
  input wire logic        wake_out,
  input wire logic        irq_out
);
  reg        tick_q;  // tick level one clock ago
  reg  [2:0] tick_h;  // recent tick rises, so slow-path events can be traced to a tick
  reg  [6:0] hcnt;    // ticks seen while chip reset is high
  wire       tick_rise = wd_tick_clock_in & ~tick_q;
  // tick history and hold counter
  always @(posedge clk_in)
  begin
    tick_q <= rst_in ? 1'b0 : wd_tick_clock_in;
    tick_h <= rst_in ? 3'b000 : {tick_h[1:0], tick_rise};
    hcnt   <= (rst_in || !chip_reset_out) ? 7'd0 : hcnt + {6'd0, tick_rise};
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  sequence s_rst_rise;
    $rose(chip_reset_out);
  endsequence
  sequence s_hold;
    chip_reset_out [*8];
  endsequence
  chk_hold_min: assert property (s_rst_rise |=> s_hold)
    else $error("chip reset too short");
  chk_hold_max: assert property (chip_reset_out |-> hcnt <= HOLD)
    else $error("chip reset held past its tick count");
  chk_hold_exact: assert property ($fell(chip_reset_out) && !$past(rst_in) |-> hcnt == HOLD)
    else $error("chip reset released at wrong tick");
  chk_reset_tick: assert property (s_rst_rise |-> tick_h != 3'b000)
    else $error("chip reset rose without a tick");
  chk_wake_tick: assert property (wake_out |-> tick_h != 3'b000)
    else $error("wake without a tick");
  chk_wake_pulse: assert property (wake_out |=> !wake_out)
    else $error("wake longer than one clock");
  chk_wake_powered: assert property (wake_out |-> $past(pwr_down_in))
    else $error("wake while powered up");
  chk_bus_okay: assert property (hreadyout_out && hresp_out == `WDTRW_HRESP_OKAY)
    else $error("bus not ready or not okay");
endmodule
bind wdtrw_top wdtrw_chk #(.CNT_W(CNT_W), .GRACE(GRACE), .HOLD(HOLD)) u_chk (
  .clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
  .hready_in(hready_in), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
  .hrdata_out(hrdata_out), .wd_tick_clock_in(wd_tick_clock_in), .pwr_down_in(pwr_down_in),
  .chip_reset_out(chip_reset_out), .wake_out(wake_out), .irq_out(irq_out));

// ### dv/wdtrw_tb_top.sv
// testbench for the watchdog block: ahb-lite register calls, tick timing and chip reset
// assumes a tick every four clocks and hreadyout fed back as hready
`timescale 1ns/100ps
`include "wdtrw_regs.vh"
module wdtrw_tb_top;
  reg         clk_in      = 1'b0;
  reg         rst_in      = 1'b1;
  reg         hsel_in     = 1'b0;
  reg  [31:0] haddr_in    = 32'h0000_0000;
  reg  [1:0]  htrans_in   = 2'b00;
  reg         hwrite_in   = 1'b0;
  reg  [31:0] hwdata_in   = 32'h0000_0000;
  reg         tick        = 1'b0;  // slow watchdog clock
  reg         pwr_down_in = 1'b0;
  reg  [1:0]  tdiv        = 2'b00; // tick divider
  reg  [31:0] rd;                  // last read data
  wire        hreadyout_out;
  wire        hresp_out;
  wire [31:0] hrdata_out;
  wire        chip_reset_out;
  wire        wake_out;
  wire        irq_out;
  integer     ntick = 0, errors = 0, comparisons = 0, cycles = 0, rst_seen = 0, wakes = 0, t0, i;
  wdtrw_top DUT (
    .clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'b010), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .hrdata_out(hrdata_out), .wd_tick_clock_in(tick), .pwr_down_in(pwr_down_in),
    .chip_reset_out(chip_reset_out), .wake_out(wake_out), .irq_out(irq_out));
  always #5 clk_in = ~clk_in;
  // ticks, event monitors and the hang limit
  always @(posedge clk_in)
  begin
    tdiv <= tdiv + 2'd1;
    tick <= tdiv[1];
    ntick <= ntick + (tdiv == 2'd1);
    cycles <= cycles + 1;
    if (chip_reset_out) rst_seen <= 1;
    if (wake_out) wakes <= wakes + 1;
    if (cycles == 40000)
    begin
      chk(32'h0000_0000, 32'h0000_0001);
      complete_run;
    end
  end
  task chk(input [31:0] s, input [31:0] e);
  begin
    comparisons = comparisons + 1;
    if (s !== e)
    begin
      errors = errors + 1;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  end
  endtask
  // one single transfer: address phase, then data phase; read data taken at its end
  task bus(input w, input [31:0] a, input [31:0] d);
  begin
    @(posedge clk_in);
    hsel_in <= 1'b1;
    haddr_in <= a;
    htrans_in <= `WDTRW_HTRANS_NONSEQ;
    hwrite_in <= w;
    @(posedge clk_in);
    while (hreadyout_out !== 1'b1) @(posedge clk_in);
    hsel_in <= 1'b0;
    htrans_in <= 2'b00;
    hwdata_in <= d;
    @(posedge clk_in);
    while (hreadyout_out !== 1'b1) @(posedge clk_in);
    rd = hrdata_out;
  end
  endtask
  task wr(input [31:0] a, input [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rdc(input [31:0] a, input [31:0] e);
  begin
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  end
  endtask
  task wait_t(input integer n);
  begin
    t0 = ntick;
    while (ntick < t0 + n) @(posedge clk_in);
  end
  endtask
  task settle;
  begin
    @(posedge clk_in);
    #1;
  end
  endtask
  task complete_run;
  begin
    $display("comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  initial
  begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    // reset values, a read-only counter and an unaligned hole
    for (i = 0; i < 16; i = i + 4) rdc(i, 32'h0000_0000);
    wr(12, 32'hffff_ffff);
    rdc(12, 32'h0000_0000);
    rdc(2, 32'h0000_0000);
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(0, i << 8);
      rdc(0, i << 8);
    end
    $display("register test done");
    // interval lengths: enable, flag, clear
    wr(8, 32'h0000_0001);
    for (i = 0; i < 4; i = i + 1)
    begin
      t0 = ntick;
      wr(0, (i << 8) | 32'h0000_00c1);
      while (irq_out !== 1'b1) @(posedge clk_in);
      chk(ntick - t0 >= (1 << (4 + 2 * i)) && ntick - t0 <= (1 << (4 + 2 * i)) + 1, 1);
      wr(4, 32'h0000_0001);
      settle;
      chk(irq_out, 1'b0);
    end
    $display("interval test done");
    // masked flag still latched; both enables gate the line
    wr(8, 32'h0000_0000);
    wr(0, 32'h0000_00c1);
    wait_t(20);
    rdc(4, 32'h0000_0001);
    chk(irq_out, 1'b0);
    wr(8, 32'h0000_0001);
    settle;
    chk(irq_out, 1'b1);
    wr(0, 32'h0000_0080);
    settle;
    chk(irq_out, 1'b0);
    $display("mask test done");
    // restart in grace holds off the reset; disable in grace cancels it
    wr(0, 32'h0000_0383);
    wait_t(1400);
    wr(0, 32'h0000_0383);
    rdc(0, 32'h0000_0382);
    rst_seen = 0;
    wait_t(1200);
    wr(0, 32'h0000_0302);
    wait_t(1100);
    chk(rst_seen, 0);
    // the stopped counter keeps the ticks it made in grace
    bus(1'b0, 12, 32'h0000_0000);
    i = rd;
    chk(i >= 170 && i <= 180, 1);
    wait_t(4);
    rdc(12, i);
    $display("restart test done");
    // unattended timeout resets the chip
    wr(4, 32'h0000_0007);
    wr(0, 32'h0000_0083);
    while (chip_reset_out !== 1'b1) @(posedge clk_in);
    t0 = ntick;
    while (chip_reset_out !== 1'b0) @(posedge clk_in);
    chk(ntick - t0 >= 62 && ntick - t0 <= 64, 1);
    rdc(4, 32'h0000_0005);
    rdc(0, 32'h0000_0000);
    $display("reset test done");
    // wake from power-down
    wr(4, 32'h0000_0007);
    pwr_down_in <= 1'b1;
    wakes = 0;
    wr(0, 32'h0000_0091);
    wait_t(20);
    chk(wakes, 1);
    rdc(4, 32'h0000_0003);
    $display("wake test done");
    // wake with reset enable: a prompt restart outlives the first grace delay
    rst_seen = 0;
    wr(0, 32'h0000_0093);
    wait_t(20);
    wr(0, 32'h0000_0093);
    wait_t(1030);
    chk(rst_seen, 0);
    chk(wakes, 3);
    $display("wake reset test done");
    complete_run;
  end
endmodule

// ### verilog/wdtrw_regs.vh
// register map, field positions, reset values and tick counts of the watchdog block
// assumes a 32-bit AHB-Lite slave port and a low-speed tick input sampled on clk_in
`ifndef WDTRW_REGS_VH
`define WDTRW_REGS_VH

// byte offsets of the word registers
`define WDTRW_ADDR_CTRL      4'h0
`define WDTRW_ADDR_STATUS    4'h4
`define WDTRW_ADDR_MASK      4'h8
`define WDTRW_ADDR_COUNT     4'hc
`define WDTRW_ADDR_W         4

// wd_control_reg fields
`define WDTRW_CTRL_RESTART   0
`define WDTRW_CTRL_RST_EN    1
`define WDTRW_CTRL_WAKE_EN   4
`define WDTRW_CTRL_IRQ_EN    6
`define WDTRW_CTRL_ENABLE    7
`define WDTRW_CTRL_SEL_LO    8
`define WDTRW_CTRL_SEL_HI    10
`define WDTRW_CTRL_RESET     32'h0000_0000

// status and mask fields, one bit per event
`define WDTRW_ST_TIMEOUT     0
`define WDTRW_ST_WAKE        1
`define WDTRW_ST_RESET       2
`define WDTRW_ST_W           3
`define WDTRW_ST_RESET_VAL   3'h0
`define WDTRW_MASK_RESET_VAL 3'h0

// counter and field widths in bits, interval base as a power of two, grace and hold figures in watchdog ticks
`define WDTRW_CNT_W          18
`define WDTRW_SEL_W          3
`define WDTRW_INTERVAL_BASE  4
`define WDTRW_GRACE_TICKS    1024
`define WDTRW_GRACE_W        11
`define WDTRW_HOLD_TICKS     63
`define WDTRW_HOLD_W         6

// nominal tick rate and system clock, used only to derive the tick period in clk_in cycles
`define WDTRW_TICK_HZ        10000
`define WDTRW_CLK_HZ         100000000

// ahb-lite encodings
`define WDTRW_HTRANS_NONSEQ  2'b10
`define WDTRW_HRESP_OKAY     1'b0

`endif

// ### verilog/wdtrw_top.v
// watchdog reset and wake-up timer with an AHB-Lite register slave and a masked interrupt
// assumes every input is synchronous to clk_in; wd_tick_clock_in is the low-speed watchdog clock
// sampled as a level, and rst_in is a power-on reset that the watchdog's own chip reset
// does not drive back into this block
//
// Contract
// - eighteen bit free running watchdog counter
// - enable bit seven starts upward counting
// - timeout sets flag; interrupt needs enable
// - grace delay of 1024 ticks follows
// - restart bit clears itself after counter clears
// - three bit select chooses interval
// - select values give two power intervals
// - grace expiry sets reset flag, resets chip
// - chip reset held sixty three ticks
// - reset flag survives watchdog reset
// - powered down timeout wakes the chip
// - counter runs on slow watchdog tick
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`include "wdtrw_regs.vh"

module wdtrw_top
#(
  parameter CNT_W = `WDTRW_CNT_W,      // watchdog counter width
  parameter GRACE = `WDTRW_GRACE_TICKS, // grace delay in ticks
  parameter HOLD  = `WDTRW_HOLD_TICKS   // chip reset length in ticks
)
(
  // clock and reset
  input  wire        clk_in,
  input  wire        rst_in,
  // ahb-lite slave
  input  wire        hsel_in,
  input  wire [31:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire [31:0] hwdata_in,
  input  wire        hready_in,
  output wire        hreadyout_out,
  output wire        hresp_out,
  output reg  [31:0] hrdata_out,
  // watchdog tick and power state
  input  wire        wd_tick_clock_in,
  input  wire        pwr_down_in,
  // outputs to the chip
  output reg         chip_reset_out,
  output reg         wake_out,
  output wire        irq_out
);

  // tick period in clk_in cycles, kept for reference by integrators
  // not read by the logic: ticks are edge-detected, so any rate below half of clk_in works
  localparam WD_TICK_PERIOD_CYC = `WDTRW_CLK_HZ / `WDTRW_TICK_HZ;

  // sequencer states, one-hot
  localparam [2:0] ST_COUNT = 3'b001;  // counting toward the interval
  localparam [2:0] ST_GRACE = 3'b010;  // grace delay after a timeout
  localparam [2:0] ST_HOLD  = 3'b100;  // chip reset being held

  // interval length for a select code: 2^(4 + 2*sel), one bit wider than the counter
  function [CNT_W:0] wdtrw_interval;
    input [`WDTRW_SEL_W-1:0] sel;
    begin
      wdtrw_interval = {{CNT_W{1'b0}}, 1'b1} << (`WDTRW_INTERVAL_BASE + 2 * sel);
    end
  endfunction

  // control register fields
  reg [`WDTRW_SEL_W-1:0]     interval_select;    // time-out interval code
  reg                        wd_enable_bit;      // counter runs while set
  reg                        timeout_irq_enable; // lets the timeout flag request an interrupt
  reg                        wake_enable;        // wake-up on timeout while powered down
  reg                        wd_reset_enable;    // grace expiry resets the chip
  reg                        counter_restart_bit;// pending restart, self-clearing

  // status and mask
  reg [`WDTRW_ST_W-1:0]      status;             // sticky event bits
  reg [`WDTRW_ST_W-1:0]      irq_mask;           // one enables the matching status bit

  // timer state
  reg [CNT_W-1:0]            wd_count;           // watchdog up-counter
  reg [`WDTRW_GRACE_W-1:0]   grace_count;        // ticks spent in grace
  reg [`WDTRW_HOLD_W-1:0]    hold_count;         // ticks of chip reset held
  reg [2:0]                  state;              // sequencer state
  reg                        tick_q;             // previous tick level for edge detect

  // ahb data-phase capture
  reg                        dp_write;           // write pending in data phase
  reg [`WDTRW_ADDR_W-1:0]    dp_addr;            // its byte offset

  // combinational helpers
  wire                       tick_rise;          // one cycle per watchdog tick
  wire                       addr_phase;         // a transfer is taken this edge
  wire [CNT_W:0]             count_inc;          // counter plus one, with carry
  wire                       timeout_hit;        // interval reached on this tick
  wire                       grace_end;          // last grace tick
  wire                       hold_end;           // last hold tick
  wire                       wr_ctrl;
  wire                       wr_status;
  wire                       wr_mask;
  wire [31:0]                ctrl_word;
  reg  [31:0]                next_rdata;
  reg  [`WDTRW_ST_W-1:0]     next_status;

  // zero-wait slave, always OKAY
  // no wait states: every register answers straight from flip-flops
  assign hreadyout_out = 1'b1;
  assign hresp_out     = `WDTRW_HRESP_OKAY;

  // pins are synchronous, so the tick is edge-detected directly
  assign tick_rise  = wd_tick_clock_in & ~tick_q;
  assign addr_phase = hsel_in & hready_in & (htrans_in == `WDTRW_HTRANS_NONSEQ);

  assign count_inc   = {1'b0, wd_count} + {{CNT_W{1'b0}}, 1'b1};
  // the carry bit lets the widest interval equal the full counter range
  assign timeout_hit = tick_rise & wd_enable_bit & (state == ST_COUNT) & ~counter_restart_bit
                       & (count_inc == wdtrw_interval(interval_select));
  assign grace_end   = tick_rise & (state == ST_GRACE)
                       & (grace_count == GRACE[`WDTRW_GRACE_W-1:0] - 1'b1);
  assign hold_end    = tick_rise & (state == ST_HOLD)
                       & (hold_count == HOLD[`WDTRW_HOLD_W-1:0] - 1'b1);

  // writes land at the end of the data phase; only the low address bits are decoded,
  // so the map repeats every sixteen bytes
  assign wr_ctrl   = dp_write & (dp_addr == `WDTRW_ADDR_CTRL);
  assign wr_status = dp_write & (dp_addr == `WDTRW_ADDR_STATUS);
  assign wr_mask   = dp_write & (dp_addr == `WDTRW_ADDR_MASK);

  // control word as software reads it
  assign ctrl_word = {21'h0, interval_select, wd_enable_bit, timeout_irq_enable, 1'b0,
                      wake_enable, 2'b00, wd_reset_enable, counter_restart_bit};

  // the timeout bit also needs its own enable, so either gate can silence it
  assign irq_out = |(status & irq_mask
                     & {{(`WDTRW_ST_W-1){1'b1}}, timeout_irq_enable});

  // tick edge detector
  // a tick already high when reset ends counts once; harmless, the counter is off then
  always @(posedge clk_in)
  begin
    if (rst_in)
      tick_q <= 1'b0;
    else
      tick_q <= wd_tick_clock_in;
  end

  // address phase capture; read data is prepared here so it stands in the data phase
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      dp_write   <= 1'b0;
      dp_addr    <= {`WDTRW_ADDR_W{1'b0}};
      hrdata_out <= 32'h0000_0000;
    end
    else
    begin
      dp_write <= addr_phase & hwrite_in;
      dp_addr  <= haddr_in[`WDTRW_ADDR_W-1:0];
      if (addr_phase & ~hwrite_in)
        hrdata_out <= next_rdata;
    end
  end

  // read mux; unmapped offsets read as zero
  // the count is taken at the address phase and may lag a tick landing in the data phase
  always @*
  begin
    next_rdata = 32'h0000_0000;
    case (haddr_in[`WDTRW_ADDR_W-1:0])
      `WDTRW_ADDR_CTRL:   next_rdata = ctrl_word;
      `WDTRW_ADDR_STATUS: next_rdata = {29'h0, status};
      `WDTRW_ADDR_MASK:   next_rdata = {29'h0, irq_mask};
      `WDTRW_ADDR_COUNT:  next_rdata = {{(32-CNT_W){1'b0}}, wd_count};
      default:            next_rdata = 32'h0000_0000;
    endcase
  end

  // control register; a watchdog chip reset returns the controls to their reset values
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      interval_select     <= 3'h0;
      wd_enable_bit       <= 1'b0;
      timeout_irq_enable  <= 1'b0;
      wake_enable         <= 1'b0;
      wd_reset_enable     <= 1'b0;
      counter_restart_bit <= 1'b0;
    end
    else if (hold_end)
    begin
      // the chip comes out of reset with the watchdog off
      interval_select     <= 3'h0;
      wd_enable_bit       <= 1'b0;
      timeout_irq_enable  <= 1'b0;
      wake_enable         <= 1'b0;
      wd_reset_enable     <= 1'b0;
      counter_restart_bit <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      interval_select     <= hwdata_in[`WDTRW_CTRL_SEL_HI:`WDTRW_CTRL_SEL_LO];
      wd_enable_bit       <= hwdata_in[`WDTRW_CTRL_ENABLE];
      timeout_irq_enable  <= hwdata_in[`WDTRW_CTRL_IRQ_EN];
      wake_enable         <= hwdata_in[`WDTRW_CTRL_WAKE_EN];
      wd_reset_enable     <= hwdata_in[`WDTRW_CTRL_RST_EN];
      // writing zero never cancels a restart already pending
      counter_restart_bit <= counter_restart_bit | hwdata_in[`WDTRW_CTRL_RESTART];
    end
    // the counter clears on this same edge, so the bit reads back as one for one clock
    else if (counter_restart_bit)
      counter_restart_bit <= 1'b0;
  end

  // counter: restart wins, then counting while enabled; disable holds the value
  // it also runs through the grace delay; a timeout inside grace is ignored
  always @(posedge clk_in)
  begin
    if (rst_in)
      wd_count <= {CNT_W{1'b0}};
    else if (counter_restart_bit | hold_end)
      wd_count <= {CNT_W{1'b0}};
    else if (timeout_hit)
      wd_count <= {CNT_W{1'b0}};
    else if (tick_rise & wd_enable_bit & (state != ST_HOLD))
      wd_count <= count_inc[CNT_W-1:0];
  end

  // sequencer: count, grace, hold
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state       <= ST_COUNT;
      grace_count <= {`WDTRW_GRACE_W{1'b0}};
      hold_count  <= {`WDTRW_HOLD_W{1'b0}};
    end
    else
    begin
      case (state)
        ST_COUNT:
        begin
          // both tick counters are parked at zero here
          grace_count <= {`WDTRW_GRACE_W{1'b0}};
          hold_count  <= {`WDTRW_HOLD_W{1'b0}};
          if (timeout_hit)
            state <= ST_GRACE;
        end
        ST_GRACE:
        begin
          // a restart or a disable abandons the grace delay
          if (counter_restart_bit | ~wd_enable_bit)
          begin
            state       <= ST_COUNT;
            grace_count <= {`WDTRW_GRACE_W{1'b0}};
          end
          else if (grace_end)
          begin
            grace_count <= {`WDTRW_GRACE_W{1'b0}};
            // without reset enable the grace delay just lapses
            state <= wd_reset_enable ? ST_HOLD : ST_COUNT;
          end
          // counts to GRACE-1; grace_end then catches the last tick
          else if (tick_rise)
            grace_count <= grace_count + 1'b1;
        end
        ST_HOLD:
        begin
          // once issued the chip reset always runs its full length
          if (hold_end)
          begin
            state      <= ST_COUNT;
            hold_count <= {`WDTRW_HOLD_W{1'b0}};
          end
          else if (tick_rise)
            hold_count <= hold_count + 1'b1;
        end
        default:
        begin
          // an illegal code falls back to counting rather than issuing a reset
          state       <= ST_COUNT;
          grace_count <= {`WDTRW_GRACE_W{1'b0}};
          hold_count  <= {`WDTRW_HOLD_W{1'b0}};
        end
      endcase
    end
  end

  // chip reset and wake outputs
  // both registered so the chip sees no glitch; wake is one clock wide and must be latched
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      chip_reset_out <= 1'b0;
      wake_out       <= 1'b0;
    end
    else
    begin
      chip_reset_out <= (state == ST_GRACE & grace_end & wd_reset_enable & wd_enable_bit
                         & ~counter_restart_bit)
                        | (state == ST_HOLD & ~hold_end);
      wake_out       <= timeout_hit & pwr_down_in & wake_enable;
    end
  end

  // sticky status: set wins over a write-one clear in the same cycle
  always @*
  begin
    next_status = status;
    if (wr_status)
      next_status = status & ~hwdata_in[`WDTRW_ST_W-1:0];
    if (timeout_hit)
      next_status[`WDTRW_ST_TIMEOUT] = 1'b1;
    if (timeout_hit & pwr_down_in & wake_enable)
      next_status[`WDTRW_ST_WAKE] = 1'b1;
    // same terms as the chip reset itself, so flag and reset never disagree
    if (state == ST_GRACE & grace_end & wd_reset_enable & wd_enable_bit & ~counter_restart_bit)
      next_status[`WDTRW_ST_RESET] = 1'b1;
  end

  // status and mask registers; only rst_in clears them, never the watchdog's own reset
  // a mask write is a plain store and never touches a status bit
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      status   <= `WDTRW_ST_RESET_VAL;
      irq_mask <= `WDTRW_MASK_RESET_VAL;
    end
    else
    begin
      status <= next_status;
      if (wr_mask)
        irq_mask <= hwdata_in[`WDTRW_ST_W-1:0];
    end
  end

endmodule
